// *** hw/qlcsr_regs.sv ***
/*
  Quad line control and status register bank, an APB slave.
  Primary bank: revision word, loopback and all-ones controls, signal-loss
  and driver-fault status with masks, interrupt status. Expanded bank of
  eight per-channel registers, chosen by the bank pointer.
  Assumes an APB master on CLK and asynchronous pins from the line side.
*/
// The APB interface to the registers was left to the implementer.
//
// Behaviour
// RULE1 - Fixed read-only eight-bit revision word
// RULE2 - Analog loopback bit per channel, reset off
// RULE3 - Remote loopback bit per channel, reset off
// RULE4 - Transmit-all-ones bit per channel, reset off
// RULE5 - Read-only signal-loss status per channel
// RULE6 - Read-only driver-fault status per channel
// RULE7 - Signal-loss interrupt mask, blocked after reset
// RULE8 - Driver-fault interrupt mask, blocked after reset
// RULE9 - Software keeps upper four bits zero
// RULE10 - Expanded bank of eight per-channel registers
// RULE11 - Bank pointer at 1F selects bank
// RULE12 - Bit n serves channel n
module qlcsr_regs
  import qlcsr_pkg::*;
#(
  parameter int CHANNELS = 4, // Channels served
  parameter logic [7:0] REVISION_CODE = 8'hA5 // Arbitrary value
) (
  input wire logic CLK, // Core clock, 250 MHz
  input wire logic NRST, // Asynchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction, high for write
  input wire logic [9:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic [3:0] PSTRB, // APB byte strobes
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic [CHANNELS-1:0] CARRIER_ABSENT, // Signal-loss detector pins
  input wire logic [CHANNELS-1:0] LINE_DRIVER_FAULT, // Driver-fault detector pins
  output logic [CHANNELS-1:0] ANALOG_LOOP_EN, // Analog loopback per channel
  output logic [CHANNELS-1:0] REMOTE_LOOP_EN, // Remote loopback per channel
  output logic [CHANNELS-1:0] ALL_ONES_TX, // Transmit all ones per channel
  output logic [EXT_REGS*CHANNELS-1:0] EXT_CFG, // Expanded bank fields, register r at [r*CH+:CH]
  output logic IRQ // Level interrupt, high while an unmasked event is pending
);

  // Refused at elaboration: eight-bit registers hold two groups of channel
  // bits in the interrupt status, and the reset pipeline needs two stages
  if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
    $error("qlcsr_regs: CHANNELS must be 1 to 4");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("qlcsr_regs: SYNC_STAGES must be at least 2");
  end

  // Phase of the current bus transfer
  typedef enum logic {
    ph_idle = 1'b0,
    ph_answer = 1'b1
  } qlcsr_phase_t;

  qlcsr_phase_t phase;
  qlcsr_phase_t next_phase;
  logic [SYNC_STAGES-1:0] rst_pipe;
  logic rst_n;
  logic [CHANNELS-1:0] analog_loop_en;
  logic [CHANNELS-1:0] remote_loop_en;
  logic [CHANNELS-1:0] all_ones_tx;
  logic [CHANNELS-1:0] carrier_absent_irq_mask;
  logic [CHANNELS-1:0] driver_fault_irq_mask;
  logic [CHANNELS-1:0] ext_cfg [EXT_REGS];
  logic [7:0] bank_pointer;
  logic [7:0] irq_status;
  logic [7:0] next_irq_status;
  logic [7:0] irq_mask;
  logic [7:0] irq_set;
  logic [31:0] next_rdata;
  logic next_err;
  logic [7:0] idx;
  logic word_ok;
  logic expanded;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic low_lane;
  logic wr_lane0;
  logic wr_pointer;
  logic wr_primary;
  logic wr_analog;
  logic wr_remote;
  logic wr_ones;
  logic wr_carrier_mask;
  logic wr_fault_mask;
  logic wr_ext;
  logic rd_status;

  qlcsr_mon_if #(.CHANNELS(CHANNELS)) mon_if ();

  // Reset release through two flip-flops; assertion stays asynchronous
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= {rst_pipe[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[SYNC_STAGES-1];

  // Pin synchronisation and change detection
  qlcsr_line_mon #(
    .CHANNELS(CHANNELS)
  ) u_line_mon (
    .clk(CLK),
    .rst_n(rst_n),
    .carrier_absent_pin(CARRIER_ABSENT),
    .driver_fault_pin(LINE_DRIVER_FAULT),
    .mon(mon_if.mon)
  );

  // Address decode; only word-aligned addresses are mapped
  assign idx = PADDR[9:2];
  assign word_ok = (PADDR[1:0] == 2'b00);
  assign expanded = (bank_pointer != BANK_PRIMARY); // RULE11
  assign access = PSEL && PENABLE;
  assign done = access && PREADY;
  assign wr_done = done && PWRITE && word_ok;
  assign rd_done = done && !PWRITE && word_ok;
  assign low_lane = PSTRB[0]; // Registers live in byte lane 0

  // Write strobes, one per register; a write lands only on a completed,
  // aligned transfer with byte lane 0 enabled
  assign wr_lane0 = wr_done && low_lane;
  assign wr_pointer = wr_lane0 && (idx == IDX_BANK_POINTER); // RULE11
  assign wr_primary = wr_lane0 && !expanded;
  assign wr_analog = wr_primary && (idx == IDX_ANALOG_LOOP);
  assign wr_remote = wr_primary && (idx == IDX_REMOTE_LOOP);
  assign wr_ones = wr_primary && (idx == IDX_ALL_ONES_TX);
  assign wr_carrier_mask = wr_primary && (idx == IDX_CARRIER_IRQ_MASK);
  assign wr_fault_mask = wr_primary && (idx == IDX_FAULT_IRQ_MASK);
  assign wr_ext = wr_lane0 && expanded && (idx <= IDX_EXT_LAST); // RULE10
  assign rd_status = rd_done && !expanded && (idx == IDX_IRQ_STATUS);

  // Read data and error for the current address, bank-dependent
  always_comb begin
    next_rdata = RST_WORD;
    next_err = 1'b0;
    if (!word_ok) begin
      next_err = 1'b1;
    end else if (idx == IDX_BANK_POINTER) begin
      next_rdata[7:0] = bank_pointer; // RULE11
    end else if (expanded) begin
      if (idx <= IDX_EXT_LAST) begin
        next_rdata[CHANNELS-1:0] = ext_cfg[idx[2:0]]; // RULE10
      end else begin
        next_err = 1'b1;
      end
    end else begin
      unique case (idx)
        IDX_CHIP_REVISION: next_rdata[7:0] = REVISION_CODE; // RULE1
        IDX_ANALOG_LOOP: next_rdata[CHANNELS-1:0] = analog_loop_en;
        IDX_REMOTE_LOOP: next_rdata[CHANNELS-1:0] = remote_loop_en;
        IDX_ALL_ONES_TX: next_rdata[CHANNELS-1:0] = all_ones_tx;
        IDX_CARRIER_ABSENT: next_rdata[CHANNELS-1:0] = mon_if.carrier_absent_flag; // RULE5
        IDX_DRIVER_FAULT: next_rdata[CHANNELS-1:0] = mon_if.line_driver_fault; // RULE6
        IDX_CARRIER_IRQ_MASK: next_rdata[CHANNELS-1:0] = carrier_absent_irq_mask;
        IDX_FAULT_IRQ_MASK: next_rdata[CHANNELS-1:0] = driver_fault_irq_mask;
        IDX_IRQ_STATUS: next_rdata[7:0] = irq_status;
        default: next_err = 1'b1;
      endcase
    end
  end

  // Next phase: an access phase not yet answered gets its answer one cycle
  // later, which gives the read mux a full cycle and keeps outputs registered
  always_comb begin
    next_phase = phase;
    unique case (phase)
      ph_idle: begin
        if (access) begin
          next_phase = ph_answer;
        end
      end
      ph_answer: begin
        next_phase = ph_idle;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ph_idle;
    end else begin
      phase <= next_phase;
    end
  end

  // Bus answer; read data and error stand only with ready
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PRDATA <= RST_WORD;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= (next_phase == ph_answer);
      if (next_phase == ph_answer) begin
        PRDATA <= PWRITE ? RST_WORD : next_rdata;
        PSLVERR <= next_err;
      end else begin
        PRDATA <= RST_WORD;
        PSLVERR <= 1'b0;
      end
    end
  end

  // Bank pointer, reachable from both banks; a full byte is kept
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      bank_pointer <= RST_BYTE;
    end else if (wr_pointer) begin
      bank_pointer <= PWDATA[7:0]; // RULE11
    end
  end

  // Analog loopback per channel. Only the channel bits are stored: the upper
  // nibble is reserved and software keeps it zero, so it reads back zero.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      analog_loop_en <= RST_CHAN_BITS[CHANNELS-1:0]; // RULE2
    end else if (wr_analog) begin
      analog_loop_en <= PWDATA[CHANNELS-1:0]; // RULE2 RULE12
    end
  end

  // Remote loopback per channel
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      remote_loop_en <= RST_CHAN_BITS[CHANNELS-1:0]; // RULE3
    end else if (wr_remote) begin
      remote_loop_en <= PWDATA[CHANNELS-1:0]; // RULE3 RULE12
    end
  end

  // Transmit all ones per channel
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      all_ones_tx <= RST_CHAN_BITS[CHANNELS-1:0]; // RULE4
    end else if (wr_ones) begin
      all_ones_tx <= PWDATA[CHANNELS-1:0]; // RULE4 RULE12
    end
  end

  // Signal-loss interrupt mask, blocked after reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      carrier_absent_irq_mask <= RST_CHAN_BITS[CHANNELS-1:0]; // RULE7
    end else if (wr_carrier_mask) begin
      carrier_absent_irq_mask <= PWDATA[CHANNELS-1:0]; // RULE7
    end
  end

  // Driver-fault interrupt mask, blocked after reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      driver_fault_irq_mask <= RST_CHAN_BITS[CHANNELS-1:0]; // RULE8
    end else if (wr_fault_mask) begin
      driver_fault_irq_mask <= PWDATA[CHANNELS-1:0]; // RULE8
    end
  end

  // Expanded bank storage, only the channel bits per entry
  for (genvar r = 0; r < EXT_REGS; r++) begin : g_ext
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        ext_cfg[r] <= RST_CHAN_BITS[CHANNELS-1:0]; // RULE10
      end else if (wr_ext && idx == 8'(r)) begin
        ext_cfg[r] <= PWDATA[CHANNELS-1:0]; // RULE10 RULE12
      end
    end
  end

  // Sticky change events; read of the status register clears it,
  // but an event in the clearing cycle still sets its bit
  always_comb begin
    irq_set = RST_BYTE;
    irq_set[IRQ_CARRIER_LSB +: CHANNELS] = mon_if.carrier_absent_evt;
    irq_set[IRQ_FAULT_LSB +: CHANNELS] = mon_if.driver_fault_evt;
    irq_mask = RST_BYTE;
    irq_mask[IRQ_CARRIER_LSB +: CHANNELS] = carrier_absent_irq_mask; // RULE7
    irq_mask[IRQ_FAULT_LSB +: CHANNELS] = driver_fault_irq_mask; // RULE8
    next_irq_status = irq_status;
    if (rd_status) begin
      next_irq_status = RST_BYTE;
    end
    next_irq_status = next_irq_status | irq_set;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RST_BYTE;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt from the next status so it follows the event without extra lag
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & irq_mask); // RULE7 RULE8
    end
  end

  // Analog loopback pins, a flop copy so the output never glitches
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ANALOG_LOOP_EN <= RST_CHAN_BITS[CHANNELS-1:0];
    end else begin
      ANALOG_LOOP_EN <= analog_loop_en; // RULE2 RULE12
    end
  end

  // Remote loopback pins, one cycle behind their register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      REMOTE_LOOP_EN <= RST_CHAN_BITS[CHANNELS-1:0];
    end else begin
      REMOTE_LOOP_EN <= remote_loop_en; // RULE3 RULE12
    end
  end

  // Transmit-all-ones pins, one cycle behind their register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ALL_ONES_TX <= RST_CHAN_BITS[CHANNELS-1:0];
    end else begin
      ALL_ONES_TX <= all_ones_tx; // RULE4 RULE12
    end
  end

  // Expanded fields out, a flop stage per entry
  for (genvar r = 0; r < EXT_REGS; r++) begin : g_ext_out
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        EXT_CFG[r*CHANNELS +: CHANNELS] <= RST_CHAN_BITS[CHANNELS-1:0];
      end else begin
        EXT_CFG[r*CHANNELS +: CHANNELS] <= ext_cfg[r];
      end
    end
  end

endmodule

// *** hw/qlcsr_pkg.sv ***
/*
  Package for the quad line control and status register bank:
  register indices, byte addresses, field positions and reset values.
  Assumes one APB slave with 32-bit data and one aligned word per register.
*/
package qlcsr_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] IDX_CHIP_REVISION = 8'h00;
  localparam logic [7:0] IDX_ANALOG_LOOP = 8'h01;
  localparam logic [7:0] IDX_REMOTE_LOOP = 8'h02;
  localparam logic [7:0] IDX_ALL_ONES_TX = 8'h03;
  localparam logic [7:0] IDX_CARRIER_ABSENT = 8'h04;
  localparam logic [7:0] IDX_DRIVER_FAULT = 8'h05;
  localparam logic [7:0] IDX_CARRIER_IRQ_MASK = 8'h06;
  localparam logic [7:0] IDX_FAULT_IRQ_MASK = 8'h07;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h08;
  localparam logic [7:0] IDX_BANK_POINTER = 8'h1F;
  localparam logic [7:0] IDX_EXT_FIRST = 8'h00;
  localparam logic [7:0] IDX_EXT_LAST = 8'h07;

  // Expanded bank size
  localparam int EXT_REGS = 8;

  // Byte address of an index
  function automatic logic [9:0] qlcsr_byte_addr(input logic [7:0] idx);
    qlcsr_byte_addr = {idx, 2'b00};
  endfunction

  // Interrupt status layout: carrier-absent changes low, driver faults high
  localparam int IRQ_CARRIER_LSB = 0;
  localparam int IRQ_FAULT_LSB = 4;

  // Bank pointer value that selects the primary bank
  localparam logic [7:0] BANK_PRIMARY = 8'h00;

  // Reset values
  localparam logic [3:0] RST_CHAN_BITS = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Depth of the reset synchroniser; the pin synchronisers in the line monitor are fixed at two flops
  localparam int SYNC_STAGES = 2;

endpackage

// *** hw/qlcsr_mon_if.sv ***
/*
  Interface between the line monitor and the register bank: synchronised
  per-channel levels and one-cycle change events.
  Assumes both ends run on the same clock.
*/
interface qlcsr_mon_if #(
  parameter int CHANNELS = 4
);
  logic [CHANNELS-1:0] carrier_absent_flag;
  logic [CHANNELS-1:0] line_driver_fault;
  logic [CHANNELS-1:0] carrier_absent_evt;
  logic [CHANNELS-1:0] driver_fault_evt;

  modport mon (
    output carrier_absent_flag,
    output line_driver_fault,
    output carrier_absent_evt,
    output driver_fault_evt
  );

  modport regs (
    input carrier_absent_flag,
    input line_driver_fault,
    input carrier_absent_evt,
    input driver_fault_evt
  );
endinterface

// *** hw/qlcsr_line_mon.sv ***
/*
  Line monitor: brings the per-channel signal-loss and driver-fault pins
  into the clock domain and flags every change on them.
  Assumes the pins are asynchronous levels and the reset is already synchronised.
*/
module qlcsr_line_mon
  import qlcsr_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [CHANNELS-1:0] carrier_absent_pin, // Raw signal-loss detectors
  input wire logic [CHANNELS-1:0] driver_fault_pin, // Raw driver-fault detectors
  qlcsr_mon_if.mon mon // Levels and change events
);

  // One synchroniser and edge detector per pin, two of each per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic los_meta;
    logic df_meta;
    logic los_last;
    logic df_last;

    // First stages are read only by the second stage
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        los_meta <= 1'b0;
        df_meta <= 1'b0;
        mon.carrier_absent_flag[ch] <= 1'b0;
        mon.line_driver_fault[ch] <= 1'b0;
      end else begin
        los_meta <= carrier_absent_pin[ch];
        df_meta <= driver_fault_pin[ch];
        mon.carrier_absent_flag[ch] <= los_meta;
        mon.line_driver_fault[ch] <= df_meta;
      end
    end

    // A transition of the clean level against its own last value is an event;
    // the first stages stay private, so no metastable value reaches the status
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        los_last <= 1'b0;
        df_last <= 1'b0;
        mon.carrier_absent_evt[ch] <= 1'b0;
        mon.driver_fault_evt[ch] <= 1'b0;
      end else begin
        los_last <= mon.carrier_absent_flag[ch];
        df_last <= mon.line_driver_fault[ch];
        mon.carrier_absent_evt[ch] <= mon.carrier_absent_flag[ch] ^ los_last;
        mon.driver_fault_evt[ch] <= mon.line_driver_fault[ch] ^ df_last;
      end
    end
  end

endmodule

// *** test/qlcsr_regs_checker.sv ***
/*
  Concurrent checks on the register bank ports: APB timing, read data,
  revision word and control pins after writes.
  Assumes it is bound to qlcsr_regs and sees only its ports.
*/
module qlcsr_chk
#(
  parameter int CHANNELS = 4,
  parameter logic [7:0] REVISION_CODE = 8'hA5
) (
  input wire logic CLK, // Clock
  input wire logic NRST, // Reset
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Enable
  input wire logic PWRITE, // Direction
  input wire logic [9:0] PADDR, // Address
  input wire logic [31:0] PWDATA, // Write data
  input wire logic [3:0] PSTRB, // Strobes
  input wire logic [31:0] PRDATA, // Read data
  input wire logic PREADY, // Ready
  input wire logic PSLVERR, // Error
  input wire logic [CHANNELS-1:0] CARRIER_ABSENT, // Loss pins
  input wire logic [CHANNELS-1:0] LINE_DRIVER_FAULT, // Fault pins
  input wire logic [CHANNELS-1:0] ANALOG_LOOP_EN, // Analog loop
  input wire logic [CHANNELS-1:0] REMOTE_LOOP_EN, // Remote loop
  input wire logic [CHANNELS-1:0] ALL_ONES_TX, // All ones
  input wire logic [qlcsr_pkg::EXT_REGS*CHANNELS-1:0] EXT_CFG, // Expanded bank
  input wire logic IRQ // Interrupt
);
  import qlcsr_pkg::*;
  logic done;
  logic [7:0] bank;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // Completed transfer
  assign done = PSEL & PENABLE & PREADY;
  // Shadow of the bank pointer, so index 0 reads can be told apart
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bank <= 8'h00;
    end else if (done && PWRITE && PADDR == 10'h07C && PSTRB[0]) begin
      bank <= PWDATA[7:0];
    end
  end
  chk_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside ready");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_odd_refused: assert property (done && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned access accepted");
  chk_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_rev_read: assert property (done && !PWRITE && PADDR == 10'h000 && bank == 8'h00
    |-> PRDATA == {24'h0, REVISION_CODE}) else $error("revision word wrong");
  chk_analog_pin: assert property (done && PWRITE && PSTRB[0] && bank == 8'h00 && PADDR == 10'h004
    |-> ##2 ANALOG_LOOP_EN == $past(PWDATA[CHANNELS-1:0], 2)) else $error("analog loop pin wrong");
  chk_remote_pin: assert property (done && PWRITE && PSTRB[0] && bank == 8'h00 && PADDR == 10'h008
    |-> ##2 REMOTE_LOOP_EN == $past(PWDATA[CHANNELS-1:0], 2)) else $error("remote loop pin wrong");
  chk_ones_pin: assert property (done && PWRITE && PSTRB[0] && bank == 8'h00 && PADDR == 10'h00C
    |-> ##2 ALL_ONES_TX == $past(PWDATA[CHANNELS-1:0], 2)) else $error("all ones pin wrong");
  // Main scenarios reached
  cov_ext_write: cover property (done && PWRITE && bank != 8'h00);
  cov_refused: cover property (PREADY && PSLVERR);
  cov_irq: cover property ($rose(IRQ));
endmodule

bind qlcsr_regs qlcsr_chk #(.CHANNELS(CHANNELS), .REVISION_CODE(REVISION_CODE)) u_chk (
  .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CARRIER_ABSENT(CARRIER_ABSENT), .LINE_DRIVER_FAULT(LINE_DRIVER_FAULT),
  .ANALOG_LOOP_EN(ANALOG_LOOP_EN), .REMOTE_LOOP_EN(REMOTE_LOOP_EN), .ALL_ONES_TX(ALL_ONES_TX),
  .EXT_CFG(EXT_CFG), .IRQ(IRQ)
);

// *** test/tb_qlcsr_regs.sv ***
/*
  Bench for qlcsr_regs: random APB traffic and pin changes compared with a model.
  Assumes the checker is compiled alongside and binds itself.
*/
module tb_qlcsr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  logic CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [9:0] PADDR;
  logic [31:0] PWDATA, PRDATA, EXT_CFG;
  logic [3:0] PSTRB, CARRIER_ABSENT, LINE_DRIVER_FAULT, ANALOG_LOOP_EN, REMOTE_LOOP_EN, ALL_ONES_TX;
  logic [3:0] p[0:8], ext[0:7];
  int mismatches, samples_checked, cycles, seed, bank, ist;
  int ix[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 31, 30};

  qlcsr_regs #(.CHANNELS(4), .REVISION_CODE(REV)) uut (
    .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CARRIER_ABSENT(CARRIER_ABSENT), .LINE_DRIVER_FAULT(LINE_DRIVER_FAULT),
    .ANALOG_LOOP_EN(ANALOG_LOOP_EN), .REMOTE_LOOP_EN(REMOTE_LOOP_EN), .ALL_ONES_TX(ALL_ONES_TX),
    .EXT_CFG(EXT_CFG), .IRQ(IRQ)
  );

  // 250 MHz clock
  initial begin
    CLK = 1'h0;
    forever #2 CLK = ~CLK;
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Model state after reset
  function automatic void mreset();
    bank = 0;
    ist = 0;
    foreach (p[i]) p[i] = 4'h0;
    foreach (ext[i]) ext[i] = 4'h0;
  endfunction

  // Expected read value of a mapped index
  function automatic int mread(input int i);
    if (i == 31) return bank;
    if (bank != 0) return ext[i];
    if (i == 0) return REV;
    if (i == 4) return CARRIER_ABSENT;
    if (i == 5) return LINE_DRIVER_FAULT;
    if (i == 8) return ist;
    return p[i];
  endfunction

  // One APB transfer; PSEL stays up after a plain read so reads can run back to back
  task automatic acc(input bit w, input int i, input bit odd);
    bit err;
    logic [31:0] d, x;
    logic [3:0] s;
    d = $random(seed);
    s = $random(seed);
    if (i == 31 && d[9]) d[7:0] = 8'h00;
    if (i != 31) d[7:4] = 4'h0;
    err = odd || !(i == 31 || i < 8 || (bank == 0 && i == 8));
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= 10'(i * 4 + odd);
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'h1;
    // No assumed latency: only the hang guard ends a stalled transfer
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    PENABLE <= 1'h0;
    chk(PREADY, 1'h1);
    chk(PSLVERR, err);
    if (!w) chk(PRDATA, err ? 0 : mread(i));
    if (!w && !err && bank == 0 && i == 8) ist = 0;
    if (w && !err && s[0]) begin
      if (i == 31) bank = d[7:0];
      else if (bank != 0) ext[i] = d[3:0];
      else if (i inside {1, 2, 3, 6, 7}) p[i] = d[3:0];
    end
    // Control pins follow one cycle after the store edge
    if (w || i == 8) begin
      PSEL <= 1'h0;
      repeat (2) @(posedge CLK);
      for (int k = 0; k < 8; k++) x[k*4+:4] = ext[k];
      chk({ALL_ONES_TX, REMOTE_LOOP_EN, ANALOG_LOOP_EN}, {p[3], p[2], p[1]});
      chk(EXT_CFG, x);
      chk(IRQ, (ist & {p[7], p[6]}) != 0);
    end
  endtask

  // Pin change; the wait covers the synchronisers and the interrupt update
  task automatic pins();
    logic [3:0] c, f;
    c = $random(seed);
    f = $random(seed);
    PSEL <= 1'h0;
    ist = ist | {f ^ LINE_DRIVER_FAULT, c ^ CARRIER_ABSENT};
    CARRIER_ABSENT <= c;
    LINE_DRIVER_FAULT <= f;
    repeat (8) @(posedge CLK);
    chk(IRQ, (ist & {p[7], p[6]}) != 0);
  endtask

  // Reset pulse, then every reset value read back
  task automatic rst_seq();
    NRST <= 1'h0;
    repeat (3) @(posedge CLK);
    mreset();
    NRST <= 1'h1;
    repeat (4) @(posedge CLK);
    chk({IRQ, ALL_ONES_TX, REMOTE_LOOP_EN, ANALOG_LOOP_EN}, 0);
    chk(EXT_CFG, 0);
    foreach (ix[k]) acc(1'h0, ix[k], 1'h0);
  endtask

  // Main sequence: random writes, reads and pin changes with one reset mid-run
  initial begin
    int r;
    seed = 94347;
    {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    CARRIER_ABSENT = 4'h0;
    LINE_DRIVER_FAULT = 4'h0;
    rst_seq();
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      if (k == 150) begin
        PSEL <= 1'h0;
        CARRIER_ABSENT <= 4'h0;
        LINE_DRIVER_FAULT <= 4'h0;
        repeat (8) @(posedge CLK);
        rst_seq();
      end else if (r[1:0] == 2'h0) begin
        pins();
      end else begin
        acc(r[2], ix[r[7:3] % 12], r[11:8] == 4'h0);
      end
    end
    test_done();
  end
endmodule
